// [rtl/adc_correction_pkg.sv]
package adc_correction_pkg;

  localparam int          CHANNELS       = 2;
  localparam int          SAMPLE_W       = 14;
  localparam int          GAIN_W         = 11;
  localparam int          OFFSET_W       = 16;
  localparam int          MAG_W          = 14;

  // register selection: group in bits 2:1, channel in bit 0
  localparam logic [1:0]  GRP_GAIN       = 2'h0;
  localparam logic [1:0]  GRP_OFFSET     = 2'h1;
  localparam logic [1:0]  GRP_RAW        = 2'h2;
  localparam logic [1:0]  GRP_CORR       = 2'h3;

  // byte lanes of a 32-bit register
  localparam logic [1:0]  LANE_COS_LO    = 2'h0;
  localparam logic [1:0]  LANE_COS_HI    = 2'h1;
  localparam logic [1:0]  LANE_SIN_LO    = 2'h2;
  localparam logic [1:0]  LANE_SIN_HI    = 2'h3;

  localparam logic [10:0] GAIN_RESET     = 11'h400;
  localparam logic [15:0] OFFSET_RESET   = 16'h0000;
  localparam logic signed [15:0] OFFSET_MIN = -16'sd2730;
  localparam logic signed [15:0] OFFSET_MAX = 16'sd2729;
  localparam logic signed [12:0] GAIN_HALF  = 13'sd1024;
  localparam int          GAIN_SHIFT     = 11;
  localparam logic [13:0] MAG_MAX        = 14'h3fff;
  localparam logic [3:0]  MODE_CALIB     = 4'h5;

  typedef struct packed {
    logic signed [13:0] sine;
    logic signed [13:0] cosine;
  } sample_pair_type;

  typedef struct packed {
    logic [10:0] sine;
    logic [10:0] cosine;
  } gain_pair_type;

  typedef struct packed {
    logic signed [15:0] sine;
    logic signed [15:0] cosine;
  } offset_pair_type;

  typedef struct packed {
    logic [15:0] sine;
    logic [15:0] cosine;
  } corrected_pair_type;

endpackage

// [rtl/adc_gain_offset_correction.sv]
// What this block does
// - sine gain low byte staged first; whole 11-bit value loads on upper-bits write.
// - cosine gain low byte staged first; whole value loads on upper-bits write.
// - sine offset low byte staged first; full 16 bits load on high-byte write.
// - cosine offset low byte staged first; full 16 bits load on high-byte write.
// - out-of-range sine offset commit keeps old value, sets sine error flag.
// - out-of-range cosine offset commit keeps old value, sets cosine error flag.
// - active automatic control may overwrite gain and offset corrections.
// - per channel unsigned 11-bit sine and cosine gain, reset to midscale.
// - per channel signed 16-bit sine and cosine offset, reset to zero.
// - corrected equals raw plus offset, times one half plus gain over 2048.
// - raw register holds sine high half, cosine low half, signed 14 bits.
// - calibration mode updates corrected values only on capture command or trigger edge.
// - other modes track corrected values continuously.
// - sine reported as sign bit 31, zero bit 30, magnitude 29:16.
// - cosine reported as sign bit 15, zero bit 14, magnitude 13:0.
// - capture command comes from host over serial interface in calibration mode.
module adc_gain_offset_correction
  import adc_correction_pkg::*;
(
  input  wire logic                                 SYS_CLK,
  input  wire logic                                 RESET,
  input  wire logic                                 REG_WR,
  input  wire logic [2:0]                           REG_SEL,
  input  wire logic [1:0]                           BYTE_SEL,
  input  wire logic [7:0]                           WR_DATA,
  input  wire logic [2:0]                           RD_SEL,
  output logic      [31:0]                          RD_DATA,
  input  wire logic                                 ADC_VALID,
  input  wire adc_correction_pkg::sample_pair_type  ADC_IN [adc_correction_pkg::CHANNELS],
  input  wire logic [3:0]                           MODE,
  input  wire logic                                 CAL_CAPTURE,
  input  wire logic                                 TRIGGER_PIN,
  input  wire logic                                 CTRL_ACTIVE,
  input  wire logic                                 CTRL_LOAD,
  input  wire logic                                 CTRL_CH,
  input  wire adc_correction_pkg::gain_pair_type    CTRL_GAIN,
  input  wire adc_correction_pkg::offset_pair_type  CTRL_OFFSET,
  input  wire logic                                 ERR_CLEAR,
  output logic      [CHANNELS-1:0]                  SINE_OFFSET_ERR,
  output logic      [CHANNELS-1:0]                  COSINE_OFFSET_ERR
);
  import adc_correction_pkg::*;

  gain_pair_type      gain_r   [CHANNELS];
  offset_pair_type    offset_r [CHANNELS];
  sample_pair_type    raw_r    [CHANNELS];
  corrected_pair_type corr_r   [CHANNELS];
  logic [7:0]         stage_r  [CHANNELS][4];
  logic               trig_r;
  logic               capture;
  logic               calib;

  ////////////////////////////////////////////////////////////////////////////////
  // correction arithmetic, sign-magnitude result

  function automatic logic [15:0] correct(input logic signed [13:0] s,
                                          input logic signed [15:0] o,
                                          input logic [10:0]        g);
    logic signed [16:0] sum;
    logic signed [12:0] fac;
    logic signed [29:0] prod;
    logic signed [18:0] q;
    logic        [18:0] mag;
    logic        [13:0] sat;
    sum  = 17'(s) + 17'(o);
    fac  = GAIN_HALF + $signed({2'b00, g});
    prod = 30'(sum) * 30'(fac);
    q    = 19'(prod >>> GAIN_SHIFT);
    mag  = (q < 0) ? 19'(-q) : 19'(q);
    sat  = (mag > 19'(MAG_MAX)) ? MAG_MAX : mag[13:0];
    return {q < 0, 1'b0, sat};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // capture control

  assign calib   = (MODE == MODE_CALIB);
  assign capture = CAL_CAPTURE | (TRIGGER_PIN != trig_r);

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      trig_r <= 1'b0;
    end else begin
      trig_r <= TRIGGER_PIN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // per-channel registers

  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
    logic               wr_gain;
    logic               wr_off;
    logic               ctrl_hit;
    logic signed [15:0] off_sin_nxt;
    logic signed [15:0] off_cos_nxt;
    logic               sin_bad;
    logic               cos_bad;
    logic               sin_commit;
    logic               cos_commit;

    assign wr_gain  = REG_WR && (REG_SEL[2:1] == GRP_GAIN) && (REG_SEL[0] == 1'(ch));
    assign wr_off   = REG_WR && (REG_SEL[2:1] == GRP_OFFSET) && (REG_SEL[0] == 1'(ch));
    assign ctrl_hit = CTRL_ACTIVE && CTRL_LOAD && (CTRL_CH == 1'(ch));

    assign off_sin_nxt = $signed({WR_DATA, stage_r[ch][LANE_SIN_LO]});
    assign off_cos_nxt = $signed({WR_DATA, stage_r[ch][LANE_COS_LO]});
    assign sin_bad     = (off_sin_nxt < OFFSET_MIN) || (off_sin_nxt > OFFSET_MAX);
    assign cos_bad     = (off_cos_nxt < OFFSET_MIN) || (off_cos_nxt > OFFSET_MAX);
    assign sin_commit  = wr_off && (BYTE_SEL == LANE_SIN_HI);
    assign cos_commit  = wr_off && (BYTE_SEL == LANE_COS_HI);

    // staged low bytes, four slots per channel: gain in the high-lane slots, offset in the low-lane slots
    always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
        stage_r[ch][LANE_COS_LO] <= 8'h00;
        stage_r[ch][LANE_COS_HI] <= 8'h00;
        stage_r[ch][LANE_SIN_LO] <= 8'h00;
        stage_r[ch][LANE_SIN_HI] <= 8'h00;
      end else begin
        if (wr_gain && BYTE_SEL == LANE_SIN_LO) begin
          stage_r[ch][LANE_SIN_HI] <= WR_DATA;
        end
        if (wr_gain && BYTE_SEL == LANE_COS_LO) begin
          stage_r[ch][LANE_COS_HI] <= WR_DATA;
        end
        if (wr_off && BYTE_SEL == LANE_SIN_LO) begin
          stage_r[ch][LANE_SIN_LO] <= WR_DATA;
        end
        if (wr_off && BYTE_SEL == LANE_COS_LO) begin
          stage_r[ch][LANE_COS_LO] <= WR_DATA;
        end
      end
    end

    // gain correction
    always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
        gain_r[ch].sine   <= GAIN_RESET;
        gain_r[ch].cosine <= GAIN_RESET;
      end else begin
        if (ctrl_hit) begin
          gain_r[ch] <= CTRL_GAIN;
        end
        if (wr_gain && BYTE_SEL == LANE_SIN_HI) begin
          gain_r[ch].sine <= {WR_DATA[2:0], stage_r[ch][LANE_SIN_HI]};
        end
        if (wr_gain && BYTE_SEL == LANE_COS_HI) begin
          gain_r[ch].cosine <= {WR_DATA[2:0], stage_r[ch][LANE_COS_HI]};
        end
      end
    end

    // offset correction with range check
    always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
        offset_r[ch].sine   <= OFFSET_RESET;
        offset_r[ch].cosine <= OFFSET_RESET;
      end else begin
        if (ctrl_hit) begin
          offset_r[ch] <= CTRL_OFFSET;
        end
        if (sin_commit && !sin_bad) begin
          offset_r[ch].sine <= off_sin_nxt;
        end
        if (cos_commit && !cos_bad) begin
          offset_r[ch].cosine <= off_cos_nxt;
        end
      end
    end

    // sticky range error flags, a new error wins over a clear
    always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
        SINE_OFFSET_ERR[ch]   <= 1'b0;
        COSINE_OFFSET_ERR[ch] <= 1'b0;
      end else begin
        if (sin_commit && sin_bad) begin
          SINE_OFFSET_ERR[ch] <= 1'b1;
        end else if (ERR_CLEAR) begin
          SINE_OFFSET_ERR[ch] <= 1'b0;
        end
        if (cos_commit && cos_bad) begin
          COSINE_OFFSET_ERR[ch] <= 1'b1;
        end else if (ERR_CLEAR) begin
          COSINE_OFFSET_ERR[ch] <= 1'b0;
        end
      end
    end

    // raw samples
    always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
        raw_r[ch] <= '0;
      end else if (ADC_VALID) begin
        raw_r[ch] <= ADC_IN[ch];
      end
    end

    // corrected values
    always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
        corr_r[ch] <= '0;
      end else if (!calib || capture) begin
        corr_r[ch].sine   <= correct(raw_r[ch].sine, offset_r[ch].sine, gain_r[ch].sine);
        corr_r[ch].cosine <= correct(raw_r[ch].cosine, offset_r[ch].cosine,
                                     gain_r[ch].cosine);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read port

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      RD_DATA <= 32'h0000_0000;
    end else begin
      unique case (RD_SEL[2:1])
        GRP_GAIN:   RD_DATA <= {5'h00, gain_r[RD_SEL[0]].sine,
                                5'h00, gain_r[RD_SEL[0]].cosine};
        GRP_OFFSET: RD_DATA <= offset_r[RD_SEL[0]];
        GRP_RAW:    RD_DATA <= {{2{raw_r[RD_SEL[0]].sine[13]}}, raw_r[RD_SEL[0]].sine,
                                {2{raw_r[RD_SEL[0]].cosine[13]}},
                                raw_r[RD_SEL[0]].cosine};
        GRP_CORR:   RD_DATA <= corr_r[RD_SEL[0]];
      endcase
    end
  end

endmodule // adc_gain_offset_correction

// [test/adc_frontend_model.sv]
module adc_frontend_model
  import adc_correction_pkg::*;
(
  input  wire logic                                send,
  input  wire adc_correction_pkg::sample_pair_type smp [CHANNELS],
  output logic                                     valid,
  output adc_correction_pkg::sample_pair_type      pins [CHANNELS]
);
  timeunit 1ns;
  timeprecision 1ps;
  // samples are shown only while valid, inverted otherwise
  always_comb begin
    valid = send;
    for (int i = 0; i < CHANNELS; i++) begin
      pins[i] = send ? smp[i] : ~smp[i];
    end
  end
endmodule // adc_frontend_model

// [test/adc_correction_monitor.sv]
module adc_correction_monitor
  import adc_correction_pkg::*;
(
  input wire logic                SYS_CLK,
  input wire logic                RESET,
  input wire logic                REG_WR,
  input wire logic [2:0]          REG_SEL,
  input wire logic [1:0]          BYTE_SEL,
  input wire logic [7:0]          WR_DATA,
  input wire logic [2:0]          RD_SEL,
  input wire logic [31:0]         RD_DATA,
  input wire logic [3:0]          MODE,
  input wire logic                CAL_CAPTURE,
  input wire logic                TRIGGER_PIN,
  input wire logic                ERR_CLEAR,
  input wire logic [CHANNELS-1:0] SINE_OFFSET_ERR,
  input wire logic [CHANNELS-1:0] COSINE_OFFSET_ERR
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  logic                  bad_hi;
  logic [2*CHANNELS-1:0] errs;
  // high byte alone puts the offset out of range
  assign bad_hi = REG_WR && REG_SEL[2:1] == GRP_OFFSET
                  && ($signed(WR_DATA) > 8'sh0a || $signed(WR_DATA) < -8'sh0b);
  assign errs = {SINE_OFFSET_ERR, COSINE_OFFSET_ERR};
  ////////////////////////////////////////////////////////////////////////////////
  a_sine_err_set: assert property (bad_hi && BYTE_SEL == LANE_SIN_HI
    |=> SINE_OFFSET_ERR[$past(REG_SEL[0])]) else $error("sine offset flag not set");
  a_cos_err_set: assert property (bad_hi && BYTE_SEL == LANE_COS_HI
    |=> COSINE_OFFSET_ERR[$past(REG_SEL[0])]) else $error("cosine offset flag not set");
  a_err_clear_all: assert property (ERR_CLEAR && !REG_WR |=> errs == '0)
    else $error("error flags not cleared");
  a_err_sticky: assert property (!ERR_CLEAR |=> (errs & $past(errs)) == $past(errs))
    else $error("error flag dropped without clear");
  a_err_cause: assert property ((errs & ~$past(errs)) != '0
    |-> $past(REG_WR && REG_SEL[2:1] == GRP_OFFSET && BYTE_SEL[0])) else $error("flag without commit");
  a_gain_pad_zero: assert property ($past(RD_SEL[2:1]) == GRP_GAIN
    |-> RD_DATA[31:27] == '0 && RD_DATA[15:11] == '0) else $error("gain unused bits set");
  a_corr_zero_bits: assert property ($past(RD_SEL[2:1]) == GRP_CORR
    |-> !RD_DATA[30] && !RD_DATA[14]) else $error("corrected bit 30 or 14 set");
  a_raw_sign_ext: assert property ($past(RD_SEL[2:1]) == GRP_RAW
    |-> RD_DATA[31:29] inside {3'h0, 3'h7} && RD_DATA[15:13] inside {3'h0, 3'h7})
    else $error("raw sample not sign extended");
  a_calib_hold: assert property (MODE == MODE_CALIB && !CAL_CAPTURE && $stable(TRIGGER_PIN)
    && !$past(RESET) && $stable(RD_SEL) && RD_SEL[2:1] == GRP_CORR ##1 $stable(RD_SEL)
    |=> $stable(RD_DATA)) else $error("corrected value moved in calibration");
  c_bad_commit: cover property (bad_hi);
  c_capture: cover property (MODE == MODE_CALIB && CAL_CAPTURE);
  c_clear: cover property (ERR_CLEAR && errs != '0);
endmodule // adc_correction_monitor

bind adc_gain_offset_correction adc_correction_monitor u_mon (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .REG_WR(REG_WR), .REG_SEL(REG_SEL), .BYTE_SEL(BYTE_SEL),
  .WR_DATA(WR_DATA), .RD_SEL(RD_SEL), .RD_DATA(RD_DATA), .MODE(MODE), .CAL_CAPTURE(CAL_CAPTURE),
  .TRIGGER_PIN(TRIGGER_PIN), .ERR_CLEAR(ERR_CLEAR), .SINE_OFFSET_ERR(SINE_OFFSET_ERR),
  .COSINE_OFFSET_ERR(COSINE_OFFSET_ERR));

// [test/adc_gain_offset_correction_tb.sv]
module adc_gain_offset_correction_tb
  import adc_correction_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, wr, send, cap, trig, cact, cload, cch, eclr, adc_v;
  logic [2:0] sel, rsel;
  logic [1:0] lane;
  logic [7:0] wdata;
  logic [3:0] mode;
  logic [31:0] rdata;
  logic [CHANNELS-1:0] serr, cerr;
  sample_pair_type smp [CHANNELS];
  sample_pair_type adc_p [CHANNELS];
  gain_pair_type cgain;
  offset_pair_type coff;
  int error_cnt, checked, cycles;
  adc_gain_offset_correction u_dut (
    .SYS_CLK(clk), .RESET(rst), .REG_WR(wr), .REG_SEL(sel), .BYTE_SEL(lane), .WR_DATA(wdata),
    .RD_SEL(rsel), .RD_DATA(rdata), .ADC_VALID(adc_v), .ADC_IN(adc_p), .MODE(mode),
    .CAL_CAPTURE(cap), .TRIGGER_PIN(trig), .CTRL_ACTIVE(cact), .CTRL_LOAD(cload),
    .CTRL_CH(cch), .CTRL_GAIN(cgain), .CTRL_OFFSET(coff), .ERR_CLEAR(eclr),
    .SINE_OFFSET_ERR(serr), .COSINE_OFFSET_ERR(cerr));
  adc_frontend_model u_adc (.send(send), .smp(smp), .valid(adc_v), .pins(adc_p));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (error_cnt == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [15:0] ec(input int s, input int o, input int g);
    int q;
    int m;
    q = ((s + o) * (1024 + g)) >>> 11;
    m = q < 0 ? -q : q;
    if (m > 16383) m = 16383;
    return {q < 0, 1'b0, m[13:0]};
  endfunction
  task automatic wb(input logic [2:0] s, input logic [1:0] l, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    sel <= s;
    lane <= l;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] s, input logic [31:0] e, input string n);
    @(posedge clk);
    rsel <= s;
    @(posedge clk);
    @(negedge clk);
    chk(n, e, rdata);
  endtask
  task automatic snd(input logic signed [13:0] s1, c1, s2, c2);
    @(posedge clk);
    send <= 1'b1;
    smp[0] <= {s1, c1};
    smp[1] <= {s2, c2};
    @(posedge clk);
    send <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(3'h0, 32'h0400_0400, "gain reset");
    rd(3'h3, 32'h0, "offset reset");
    wb(3'h0, LANE_SIN_LO, 8'h34);
    rd(3'h0, 32'h0400_0400, "gain staged");
    wb(3'h0, LANE_SIN_HI, 8'hfd);
    rd(3'h0, 32'h0534_0400, "gain sine");
    wb(3'h1, LANE_COS_LO, 8'hff);
    wb(3'h1, LANE_COS_HI, 8'h07);
    rd(3'h1, 32'h0400_07ff, "gain cosine");
    wb(3'h2, LANE_COS_LO, 8'h56);
    wb(3'h2, LANE_COS_HI, 8'hf5);
    wb(3'h2, LANE_SIN_LO, 8'ha9);
    wb(3'h2, LANE_SIN_HI, 8'h0a);
    rd(3'h2, 32'h0aa9_f556, "offset limits");
    wb(3'h2, LANE_SIN_LO, 8'haa);
    wb(3'h2, LANE_SIN_HI, 8'h0a);
    wb(3'h2, LANE_SIN_HI, 8'h80);
    wb(3'h3, LANE_COS_LO, 8'h55);
    wb(3'h3, LANE_COS_HI, 8'hf5);
    rd(3'h2, 32'h0aa9_f556, "sine offset kept");
    rd(3'h3, 32'h0, "cosine offset kept");
    chk("error flags", 32'h6, {28'h0, serr, cerr});
    @(posedge clk);
    eclr <= 1'b1;
    @(posedge clk);
    eclr <= 1'b0;
    @(negedge clk);
    chk("flags cleared", 32'h0, {28'h0, serr, cerr});
  endtask
  task automatic t_data;
    snd(14'sh1fff, -14'sh2000, -14'sh2000, 14'sh1fff);
    rd(3'h4, 32'h1fff_e000, "raw");
    rd(3'h6, {ec(8191, 2729, 1332), ec(-8192, -2730, 1024)}, "corr ch1");
    rd(3'h7, {ec(-8192, 0, 1024), ec(8191, 0, 2047)}, "corr ch2");
    @(posedge clk);
    cact <= 1'b1;
    cload <= 1'b1;
    cch <= 1'b1;
    cgain <= {11'h7ff, 11'h7ff};
    coff <= {16'h7000, 16'h9000};
    @(posedge clk);
    cload <= 1'b0;
    rd(3'h1, 32'h07ff_07ff, "controller gain");
    rd(3'h7, 32'h3fff_bfff, "saturation");
  endtask
  task automatic t_calib;
    @(posedge clk);
    mode <= MODE_CALIB;
    snd(14'sh0, 14'sh0, 14'sh0, 14'sh0);
    rd(3'h6, {ec(8191, 2729, 1332), ec(-8192, -2730, 1024)}, "calib hold");
    @(posedge clk);
    cap <= 1'b1;
    @(posedge clk);
    cap <= 1'b0;
    rd(3'h6, {ec(0, 2729, 1332), ec(0, -2730, 1024)}, "capture command");
    snd(14'sh64, -14'sh64, 14'sh0, 14'sh0);
    @(posedge clk);
    trig <= ~trig;
    rd(3'h6, {ec(100, 2729, 1332), ec(-100, -2730, 1024)}, "trigger edge");
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    {rst, wr, send, cap, trig, cact, cload, cch, eclr} = 9'h100;
    {sel, rsel, lane, wdata, mode, cgain, coff} = '0;
    smp = '{default: '0};
    {error_cnt, checked, cycles} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_data();
    t_calib();
    report_and_stop();
  end
endmodule // adc_gain_offset_correction_tb
